// ==== shared/msif_pkg.sv ====
// msif_pkg: constants, offsets and carrier types of the message interrupt frame block.
// assumes one 4KB window per frame, frames stacked back to back on the access port.
package msif_pkg;

  localparam int          ADDR_W       = 16;          // access port address width, 16 frames of 4KB
  localparam int          FRAME_AW     = 12;          // 4KB frame, byte address inside a frame
  localparam int          NUM_SPI      = 1020;        // interrupt ids 0..1019 on the controller side
  localparam int          SPI_IDW      = 10;          // width of an interrupt id field
  localparam int          REG_W        = 32;          // every register is one 32-bit word

  // register offsets inside a frame
  localparam logic [11:0] OFF_TYPE     = 12'h008;     // frame_type_info, read only
  localparam logic [11:0] OFF_DOORBELL = 12'h040;     // interrupt_doorbell, write only
  localparam logic [11:0] OFF_IDENT    = 12'hfcc;     // frame_identification, read only

  // field positions
  localparam int          TYPE_BASE_LSB = 16;         // lowest allocated id, bits 25:16
  localparam int          TYPE_CNT_LSB  = 0;          // number of allocated ids, bits 9:0
  localparam int          DB_ID_LSB     = 0;          // doorbell id, bits 9:0
  localparam logic [3:0]  IDENT_ARCH    = 4'h0;       // architecture version field, bits 19:16
  localparam logic [1:0]  DB_LOW_LANES  = 2'h3;       // low half word lanes that must be written

  // values after reset
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // request from the memory side, one beat per cycle
  typedef struct packed {
    logic              valid;                         // request present this cycle
    logic              write;                         // 1 write, 0 read
    logic              secure;                        // secure attribute of the access
    logic [ADDR_W-1:0] addr;                          // byte address across all frames
    logic [3:0]        be;                            // byte enables, lane 0 is bits 7:0
    logic [REG_W-1:0]  wdata;                         // little-endian write data
  } msif_req_t;

  // answer, one cycle after each request
  typedef struct packed {
    logic             valid;                          // answer present this cycle
    logic [REG_W-1:0] rdata;                          // read data, zero for writes
  } msif_resp_t;

endpackage : msif_pkg

// ==== hdl/msif_frames.sv ====
// msif_frames: non-secure frame copies plus an optional secure frame that turn
// doorbell writes into one-cycle edges on the controller's shared interrupt lines.
// assumes the request port is on sys_clk_i and the controller samples edge pulses.
//
// Functional notes
// - doorbell write pulses matching controller interrupt line
// - secure frame needs controller security support
// - without secure frame every message is non-secure
// - secure support adds a separate secure frame
// - configurable number of non-secure frame copies
// - each non-secure copy owns contiguous id range
// - secure frame owns its own contiguous range
// - secure and non-secure ranges never overlap
// - message lines driven only by these frames
// - each frame spans 4KB of 32-bit registers
// - non-secure frame accepts non-secure accesses
// - type register at 0x008, neighbours reserved
// - doorbell at 0x040, 0x044-0xfc8 reserved
// - identification at 0xfcc, above implementation space
// - doorbell id bits 9:0, out-of-range ignored
// - type gives base 25:16, count 9:0
// - word accesses, doorbell also 16-bit writes
// - secure frame answers only secure accesses
`timescale 1ns/10ps

module msif_frames import msif_pkg::*; #(
  parameter int          NUM_NS      = 2,              // non-secure frame copies
  parameter logic [9:0]  NS_BASE     = 10'd64,         // lowest id of copy 0
  parameter logic [9:0]  NS_COUNT    = 10'd32,         // ids per non-secure copy
  parameter bit          SEC_FRAME   = 1'b1,           // secure frame built in
  parameter bit          CTRL_SEC    = 1'b1,           // controller has security support
  parameter logic [9:0]  S_BASE      = 10'd512,        // lowest id of the secure frame
  parameter logic [9:0]  S_COUNT     = 10'd16,         // ids of the secure frame
  parameter logic [11:0] PRODUCT_ID  = 12'h001,        // arbitrary value
  parameter logic [3:0]  REVISION    = 4'h0,           // arbitrary value
  parameter logic [11:0] IMPLEMENTER = 12'h000         // arbitrary value
) (
  input  wire logic               sys_clk_i,           // 20 MHz system clock
  input  wire logic               reset_n_i,           // synchronous, active low
  input  wire msif_req_t          req_i,               // register access request
  output msif_resp_t              resp_o,              // answer one cycle later
  output logic [NUM_SPI-1:0]      spi_edge_o           // one-cycle edge per interrupt id
);

  // a secure frame without controller security is not a legal pairing: drop it
  localparam bit SEC_OK = SEC_FRAME && CTRL_SEC;

  localparam logic [REG_W-1:0] IDENT_VAL = {PRODUCT_ID, IDENT_ARCH, REVISION, IMPLEMENTER};

  logic [ADDR_W-FRAME_AW-1:0] frame_idx;               // which 4KB window
  logic [FRAME_AW-1:0]        offset;                  // byte offset inside the window
  logic                       ns_hit;                  // a non-secure copy is addressed
  logic                       s_hit;                   // secure frame addressed with secure attribute
  logic                       frame_ok;                // access reaches a live frame
  logic [9:0]                 base_sel;                // id range base of the addressed frame
  logic [9:0]                 cnt_sel;                 // id range size of the addressed frame
  logic [SPI_IDW-1:0]         db_id;                   // id carried by a doorbell write
  logic                       in_range;                // id belongs to the addressed frame
  logic                       db_fire;                 // doorbell write that raises an edge
  logic [REG_W-1:0]           rdata_next;              // read mux result

  logic [NUM_SPI-1:0]         spi_pulse_reg;           // registered edge pulses
  msif_resp_t                 resp_reg;                // registered answer

  // frame decode: copies 0..NUM_NS-1 first, secure frame right after them
  always_comb begin
    frame_idx = req_i.addr[ADDR_W-1:FRAME_AW];
    offset    = req_i.addr[FRAME_AW-1:0];
    ns_hit    = int'(frame_idx) < NUM_NS;
    // non-secure accesses to the secure frame see nothing, as if unmapped
    s_hit     = SEC_OK && (int'(frame_idx) == NUM_NS) && req_i.secure;
    frame_ok  = ns_hit || s_hit;
  end

  // id range of the addressed frame; copies sit side by side so none overlap
  always_comb begin
    if (s_hit) begin
      base_sel = S_BASE;
      cnt_sel  = S_COUNT;
    end else begin
      base_sel = 10'(int'(NS_BASE) + int'(frame_idx) * int'(NS_COUNT));
      cnt_sel  = NS_COUNT;
    end
  end

  // doorbell qualification: id window check, and only writes that enable both low half word lanes
  always_comb begin
    db_id    = req_i.wdata[DB_ID_LSB +: SPI_IDW];
    in_range = ({1'b0, db_id} >= {1'b0, base_sel}) &&
               ({1'b0, db_id} < ({1'b0, base_sel} + {1'b0, cnt_sel}));
    // writes elsewhere in the frame fall through with no effect
    db_fire  = req_i.valid && req_i.write && frame_ok && (offset == OFF_DOORBELL) &&
               (req_i.be[1:0] == DB_LOW_LANES) && in_range;
  end

  // read mux; reserved and implementation-specific space reads zero
  always_comb begin
    rdata_next = RDATA_RESET;
    if (req_i.valid && !req_i.write && frame_ok) begin
      unique case (offset)
        OFF_TYPE: begin
          rdata_next[TYPE_BASE_LSB +: SPI_IDW] = base_sel;
          rdata_next[TYPE_CNT_LSB  +: SPI_IDW] = cnt_sel;
        end
        OFF_IDENT: begin
          rdata_next = IDENT_VAL;
        end
        default: begin
          rdata_next = RDATA_RESET;                                        // reserved space
        end
      endcase
    end
  end

  // one pulse flop per interrupt line; no other source reaches these lines
  // with no secure frame there is no secure path, so all pulses are non-secure messages
  for (genvar g = 0; g < NUM_SPI; g++) begin : g_line
    always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
        spi_pulse_reg[g] <= 1'b0;
      end else begin
        spi_pulse_reg[g] <= db_fire && (int'(db_id) == g);
      end
    end
  end

  // answer register: every request gets exactly one answer one cycle later
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      resp_reg <= '0;
    end else begin
      resp_reg.valid <= req_i.valid;
      resp_reg.rdata <= rdata_next;
    end
  end

  assign spi_edge_o = spi_pulse_reg;
  assign resp_o     = resp_reg;

  // helper flops remembering last cycle's decode, read only by assertions
  logic               h_fire;
  logic [SPI_IDW-1:0] h_id;
  logic               h_wr_db;
  logic               h_rd_type;
  logic               h_rd_rsvd;
  logic [9:0]         h_base;
  logic [9:0]         h_cnt;
  logic               h_ns_to_s;
  always_ff @(posedge sys_clk_i) begin
    h_fire    <= db_fire;
    h_id      <= db_id;
    h_wr_db   <= req_i.valid && req_i.write && frame_ok && offset == OFF_DOORBELL &&
                 req_i.be[1:0] == DB_LOW_LANES;
    h_rd_type <= req_i.valid && !req_i.write && frame_ok && offset == OFF_TYPE;
    h_rd_rsvd <= req_i.valid && !req_i.write && offset != OFF_TYPE && offset != OFF_IDENT;
    h_base    <= base_sel;
    h_cnt     <= cnt_sel;
    h_ns_to_s <= req_i.valid && req_i.write && (int'(frame_idx) == NUM_NS) && !req_i.secure;
  end

  a_edge_on_id: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    h_fire |-> spi_edge_o[h_id]) else $error("doorbell write gave no edge");
  a_edge_single: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $onehot0(spi_edge_o)) else $error("more than one interrupt edge at once");
  a_edge_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (spi_edge_o != '0) |=> (spi_edge_o == '0) || $past(db_fire))
    else $error("edge pulse held longer than one cycle");
  a_range_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (h_wr_db && ((h_id < h_base) || ({1'b0, h_id} >= {1'b0, h_base} + {1'b0, h_cnt})))
    |-> (spi_edge_o == '0)) else $error("out-of-range doorbell raised an edge");
  a_range_take: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (h_wr_db && h_id >= h_base && {1'b0, h_id} < {1'b0, h_base} + {1'b0, h_cnt})
    |-> spi_edge_o[h_id]) else $error("in-range doorbell was dropped");
  a_type_fields: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    h_rd_type |-> resp_o.valid && resp_o.rdata == {6'h00, h_base, 6'h00, h_cnt})
    else $error("type register fields wrong");
  a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    h_rd_rsvd |-> resp_o.rdata == RDATA_RESET) else $error("reserved read not zero");
  a_secure_only: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (h_ns_to_s && !$past(ns_hit)) |-> spi_edge_o == '0)
    else $error("non-secure access fired secure frame");
  a_resp_follow: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    req_i.valid |=> resp_o.valid) else $error("request got no answer");
  a_no_overlap: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !SEC_OK || ({1'b0, S_BASE} + {1'b0, S_COUNT} <= {1'b0, NS_BASE}) ||
    (int'(S_BASE) >= int'(NS_BASE) + NUM_NS * int'(NS_COUNT)))
    else $error("secure and non-secure id ranges overlap");

endmodule : msif_frames

// ==== testbench/msif_rc_model.sv ====
// msif_rc_model: stand-in for the root complex that sends message writes and register reads.
// assumes the frames take a request at the edge where valid is high and answer one cycle later.
`timescale 1ns/10ps

module msif_rc_model import msif_pkg::*; (
  input  wire logic sys_clk_i,  // system clock
  output msif_req_t req_o       // request into the frames
);
  // idle from time zero, before reset is released
  initial begin
    req_o = '0;
  end

  // one access: launched after an edge, taken at the next edge, then the bus is let go
  task automatic access(input logic wr, input logic sec, input logic [ADDR_W-1:0] a,
                        input logic [3:0] be, input logic [REG_W-1:0] wd);
    @(posedge sys_clk_i);
    req_o <= '{valid: 1'b1, write: wr, secure: sec, addr: a, be: be, wdata: wd};
    @(posedge sys_clk_i);
    // released fields show the inverse, so a stale value can never pass for a live one
    req_o <= '{valid: 1'b0, write: ~wr, secure: ~sec, addr: ~a, be: ~be, wdata: ~wd};
  endtask : access
endmodule : msif_rc_model

// ==== testbench/testbench.sv ====
// testbench: register reads and doorbell writes into two non-secure frames and the secure frame.
// assumes default frame parameters: ranges 64..95, 96..127 and secure 512..527.
`timescale 1ns/10ps

module testbench import msif_pkg::*; ;
  logic               sys_clk_i;    // 20 MHz clock
  logic               reset_n_i;    // active low, synchronous
  msif_req_t          req_i;        // request from the model
  msif_resp_t         resp_o;       // answer of the frames
  logic [NUM_SPI-1:0] spi_edge_o;   // edges toward the controller
  msif_resp_t         nosec_resp;   // answer of the copy built without controller security
  logic [NUM_SPI-1:0] nosec_edge;   // edges of that copy
  int                 miscompares;  // mismatches seen
  int                 check_count;  // comparisons made

  msif_frames i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .resp_o(resp_o),
                     .spi_edge_o(spi_edge_o));
  // secure frame asked for without controller security: the illegal pairing must prune that frame
  msif_frames #(.CTRL_SEC(1'b0)) i_dut_nosec (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
                                           .resp_o(nosec_resp), .spi_edge_o(nosec_edge));
  msif_rc_model i_rc (.sys_clk_i(sys_clk_i), .req_o(req_i));

  // 50 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // wide compare so one task serves data words and edge vectors
  task automatic check(input logic [NUM_SPI-1:0] seen, input logic [NUM_SPI-1:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: %s mismatch", $time, what);
    end
  endtask : check

  // one access, then the answer and the edge lines checked in the cycle that they stand
  task automatic xfer(input logic wr, input logic sec, input logic [ADDR_W-1:0] a, input logic [3:0] be,
                      input logic [REG_W-1:0] wd, input logic [REG_W-1:0] exp_rd, input int id);
    logic [NUM_SPI-1:0] e;
    logic               sec_page;
    e        = '0;
    sec_page = (a[ADDR_W-1:FRAME_AW] == 4'h2);  // window right after the two non-secure copies
    if (id >= 0) e[id] = 1'b1;  // exactly one line expected, or none
    i_rc.access(wr, sec, a, be, wd);
    #1;
    check(NUM_SPI'(resp_o.valid), NUM_SPI'(1'b1), "answer valid");
    check(NUM_SPI'(resp_o.rdata), NUM_SPI'(exp_rd), "read data");
    check(spi_edge_o, e, "interrupt edge");
    // pruned secure frame: its window reads zero and rings nothing, the copies behave as usual
    check(NUM_SPI'(nosec_resp.rdata), sec_page ? '0 : NUM_SPI'(exp_rd), "pruned frame read data");
    check(nosec_edge, sec_page ? '0 : e, "pruned frame edge");
    // one cycle later answer and edge are gone, so an edge-triggered input counts each message once
    @(posedge sys_clk_i);
    #1;
    check(NUM_SPI'(resp_o.valid), '0, "answer after its cycle");
    check(spi_edge_o, '0, "edge after its cycle");
  endtask : xfer

  task automatic rd(input logic sec, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    xfer(1'b0, sec, a, 4'hf, 32'h0000_0000, exp, -1);
  endtask : rd

  task automatic wr(input logic sec, input logic [ADDR_W-1:0] a, input logic [3:0] be,
                    input logic [REG_W-1:0] wd, input int id);
    xfer(1'b1, sec, a, be, wd, 32'h0000_0000, id);
  endtask : wr

  // verdict in one place
  task automatic test_done();
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    reset_n_i   = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    #1;
    check(spi_edge_o, '0, "edges in reset");
    check(NUM_SPI'(resp_o.valid), '0, "answer in reset");
    rd(1'b0, 16'h0008, 32'h0040_0020);
    rd(1'b0, 16'h1008, 32'h0060_0020);
    rd(1'b1, 16'h2008, 32'h0200_0010);
    rd(1'b0, 16'h2008, 32'h0000_0000);
    rd(1'b0, 16'h0fcc, 32'h0010_0000);
    rd(1'b0, 16'h0000, 32'h0000_0000);
    rd(1'b0, 16'h003c, 32'h0000_0000);
    rd(1'b0, 16'h0044, 32'h0000_0000);
    rd(1'b0, 16'h0fc8, 32'h0000_0000);
    rd(1'b0, 16'h3008, 32'h0000_0000);
    wr(1'b0, 16'h0040, 4'hf, 32'd64, 64);
    wr(1'b0, 16'h0040, 4'hf, 32'd95, 95);
    wr(1'b0, 16'h0040, 4'hf, 32'd96, -1);
    wr(1'b0, 16'h0040, 4'hf, 32'd63, -1);
    wr(1'b0, 16'h1040, 4'hf, 32'd96, 96);
    wr(1'b0, 16'h0040, 4'h3, 32'd70, 70);
    wr(1'b0, 16'h0040, 4'hc, 32'd70, -1);
    // secure-range ids are rung only through the secure window, as befits group 0 lines
    wr(1'b1, 16'h2040, 4'hf, 32'd527, 527);
    wr(1'b1, 16'h2040, 4'hf, 32'd528, -1);
    wr(1'b0, 16'h2040, 4'hf, 32'd512, -1);
    wr(1'b1, 16'h0040, 4'hf, 32'd64, 64);
    wr(1'b0, 16'h0044, 4'hf, 32'd65, -1);
    wr(1'b0, 16'h0008, 4'hf, 32'd66, -1);
    rd(1'b0, 16'h0008, 32'h0040_0020);
    test_done();
  end
endmodule : testbench
